// [logic/esf_filter.sv]
/*
  External snoop filter: observes master requests and snoop traffic, tracks
  allocated lines, filters snoops and reclaims entries near capacity.
  Assumes all inputs come from interconnect logic on clk_sys; *_fire inputs
  are completed address handshakes of the master's requests.
*/
`timescale 1ns/10ps
module esf_filter
  import esf_pkg::*;
#(
  parameter int ADDR_W    = ESF_ADDR_W,
  parameter int LINE_LOG2 = ESF_LINE_LOG2,
  parameter int LINES     = ESF_LINES,
  parameter int EXTRA     = ESF_EXTRA
) (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 rd_obs_fire,
  input  wire logic [ADDR_W-1:0]    rd_obs_addr,
  input  wire logic [3:0]           rd_obs_snoop,
  input  wire logic [1:0]           rd_obs_domain,
  input  wire logic                 rd_obs_bar,
  input  wire logic                 wr_obs_fire,
  input  wire logic [ADDR_W-1:0]    wr_obs_addr,
  input  wire logic [2:0]           wr_obs_snoop,
  input  wire logic [1:0]           wr_obs_domain,
  input  wire logic                 wr_obs_bar,
  input  wire logic                 snp_in_valid,
  output logic                      snp_in_ready,
  input  wire logic [ADDR_W-1:0]    snp_in_addr,
  input  wire logic [ESF_SNP_W-1:0] snp_in_type,
  output logic                      cr_out_valid,
  input  wire logic                 cr_out_ready,
  output logic [ESF_CR_W-1:0]       cr_out_resp,
  output logic                      snp_m_valid,
  input  wire logic                 snp_m_ready,
  output logic [ADDR_W-1:0]         snp_m_addr,
  output logic [ESF_SNP_W-1:0]      snp_m_type,
  input  wire logic                 cr_m_valid,
  output logic                      cr_m_ready,
  input  wire logic [ESF_CR_W-1:0]  cr_m_resp,
  output logic [$clog2(LINES+EXTRA+1)-1:0] tracked_count,
  output logic                      overflow
);

  localparam int DEPTH = LINES + EXTRA;   // RULE18 RULE19
  localparam int TW    = ADDR_W - LINE_LOG2;
  localparam int IW    = $clog2(DEPTH);
  localparam int CW    = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] RECLAIM_AT = CW'(DEPTH - 1);

  initial begin
    if (LINES < 1 || EXTRA < 1 || LINE_LOG2 < 2 || TW < 1)
      $error("esf_filter: unsupported geometry");
  end

  function automatic logic [TW-1:0] line_of(input logic [ADDR_W-1:0] a);
    line_of = a[ADDR_W-1:LINE_LOG2];
  endfunction : line_of

  function automatic logic [CW-1:0] ones(input logic [DEPTH-1:0] v);
    ones = '0;
    for (int i = 0; i < DEPTH; i++) ones = ones + CW'(v[i]);
  endfunction : ones

  logic [DEPTH-1:0]         valid_ff;
  logic [DEPTH-1:0]         nxt_valid;
  logic [DEPTH-1:0][TW-1:0] tag_ff;
  esf_state_t               state_ff;
  esf_state_t               nxt_state;
  logic [ADDR_W-1:0]        cur_addr_ff;
  logic [ESF_SNP_W-1:0]     type_ff;
  logic [ESF_CR_W-1:0]      resp_ff;
  logic [IW-1:0]            vict_ff;
  logic [CW-1:0]            cnt_ff;
  logic                     ovf_ff;

  wire [TW-1:0] rd_line = line_of(rd_obs_addr);
  wire [TW-1:0] wr_line = line_of(wr_obs_addr);
  wire [TW-1:0] sn_key  = (state_ff == ESF_IDLE) ? line_of(snp_in_addr)
                                                 : line_of(cur_addr_ff);

  // request classification; taken at the address handshake, never the response
  wire rd_nosnp = rd_obs_snoop == RD_NOSNP_ONCE &&
                  (rd_obs_domain == DOM_NONSH || rd_obs_domain == DOM_SYSTEM); // RULE16
  wire rd_code_alloc = rd_obs_snoop == RD_CLEAN || rd_obs_snoop == RD_NSD ||
                       rd_obs_snoop == RD_SHARED || rd_obs_snoop == RD_UNIQUE ||
                       rd_obs_snoop == CLN_UNIQUE || rd_obs_snoop == MK_UNIQUE; // RULE5
  wire rd_alloc = rd_obs_fire && !rd_obs_bar && !rd_nosnp && rd_code_alloc; // RULE1 RULE4 RULE8
  wire rd_evict = rd_obs_fire && !rd_obs_bar &&
                  (rd_obs_snoop == CLN_INVAL || rd_obs_snoop == MK_INVAL); // RULE6
  wire wr_nosnp = wr_obs_domain == DOM_NONSH || wr_obs_domain == DOM_SYSTEM;
  wire wr_evict = wr_obs_fire && !wr_obs_bar && !(wr_nosnp && wr_obs_snoop == WR_NOSNP_UNQ) &&
                  (wr_obs_snoop == WR_BACK || wr_obs_snoop == WR_DROP ||
                   wr_obs_snoop == WR_EVICT); // RULE2 RULE3 RULE6

  logic          rd_hit;
  logic [IW-1:0] rd_idx;
  logic          fr_any;
  logic [IW-1:0] fr_idx;
  logic          wr_hit;
  logic [IW-1:0] wr_idx;
  logic          sn_hit;
  logic [IW-1:0] sn_idx;

  esf_match #(.DEPTH(DEPTH), .TW(TW), .IW(IW)) u_rd_match (
    .valid    (valid_ff),
    .tags     (tag_ff),
    .key      (rd_line),
    .hit      (rd_hit),
    .hit_idx  (rd_idx),
    .free     (fr_any),
    .free_idx (fr_idx)
  );

  esf_match #(.DEPTH(DEPTH), .TW(TW), .IW(IW)) u_wr_match (
    .valid    (valid_ff),
    .tags     (tag_ff),
    .key      (wr_line),
    .hit      (wr_hit),
    .hit_idx  (wr_idx),
    .free     (),
    .free_idx ()
  );

  esf_match #(.DEPTH(DEPTH), .TW(TW), .IW(IW)) u_sn_match (
    .valid    (valid_ff),
    .tags     (tag_ff),
    .key      (sn_key),
    .hit      (sn_hit),
    .hit_idx  (sn_idx),
    .free     (),
    .free_idx ()
  );

  // speculative reads repeat lines: allocate only on a miss
  wire do_alloc  = rd_alloc && !rd_hit && fr_any; // RULE17
  wire cr_m_fire = cr_m_valid && cr_m_ready;
  wire rel       = cr_m_fire && sn_hit && !cr_m_resp[CR_SHARED]; // RULE10 RULE22
  wire ev_need   = cnt_ff >= RECLAIM_AT; // RULE20
  wire snp_take  = snp_in_valid && snp_in_ready;

  assign snp_in_ready = state_ff == ESF_IDLE && !ev_need;
  assign snp_m_valid  = state_ff == ESF_FWD || state_ff == ESF_EVS;
  assign snp_m_addr   = cur_addr_ff;
  assign snp_m_type   = type_ff;
  assign cr_m_ready   = state_ff == ESF_WAIT || state_ff == ESF_EVR;
  assign cr_out_valid = state_ff == ESF_RET || state_ff == ESF_OWN;
  assign cr_out_resp  = resp_ff;
  assign tracked_count = cnt_ff;
  assign overflow      = ovf_ff;

  // clears first, then the single allocation into a slot that was free
  always_comb begin
    nxt_valid = valid_ff;
    if (rd_evict && rd_hit) nxt_valid[rd_idx] = 1'b0; // RULE6
    if (wr_evict && wr_hit) nxt_valid[wr_idx] = 1'b0; // RULE2
    if (rel) nxt_valid[sn_idx] = 1'b0; // RULE10
    if (do_alloc) nxt_valid[fr_idx] = 1'b1; // RULE4
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ESF_IDLE: begin
        if (ev_need && valid_ff[vict_ff]) nxt_state = ESF_EVS;
        else if (snp_take) nxt_state = sn_hit ? ESF_FWD : ESF_OWN; // RULE21
      end
      ESF_FWD:  if (snp_m_ready) nxt_state = ESF_WAIT;
      ESF_WAIT: if (cr_m_fire) nxt_state = ESF_RET;
      ESF_RET:  if (cr_out_ready) nxt_state = ESF_IDLE;
      ESF_OWN:  if (cr_out_ready) nxt_state = ESF_IDLE;
      ESF_EVS:  if (snp_m_ready) nxt_state = ESF_EVR;
      ESF_EVR:  if (cr_m_fire) nxt_state = ESF_IDLE;
      default:  nxt_state = ESF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff <= ESF_IDLE;
      valid_ff <= '0;
      cnt_ff   <= '0;
      ovf_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      valid_ff <= nxt_valid;
      cnt_ff   <= ones(nxt_valid);
      // lost tracking is sticky until reset
      if (rd_alloc && !rd_hit && !fr_any) ovf_ff <= 1'b1;
    end
  end

  // tag store needs no reset: valid_ff qualifies every entry
  always_ff @(posedge clk_sys) begin
    if (do_alloc) tag_ff[fr_idx] <= rd_line;
  end

  // snoop context and round-robin victim
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cur_addr_ff <= '0;
      type_ff     <= '0;
      resp_ff     <= CR_NONE;
      vict_ff     <= '0;
    end else if (state_ff == ESF_IDLE && ev_need) begin
      if (valid_ff[vict_ff]) begin
        cur_addr_ff <= {tag_ff[vict_ff], {LINE_LOG2{1'b0}}};
        type_ff     <= SNP_RECLAIM; // RULE20
      end
      vict_ff <= (vict_ff == IW'(DEPTH - 1)) ? '0 : vict_ff + 1'b1;
    end else if (snp_take) begin
      cur_addr_ff <= snp_in_addr;
      type_ff     <= snp_in_type;
      resp_ff     <= CR_NONE; // RULE21
    end else if (state_ff == ESF_WAIT && cr_m_fire) begin
      resp_ff <= cr_m_resp;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  wire quiet = !wr_obs_fire && !cr_m_fire;

  sequence s_fwd_out;
    snp_m_valid && state_ff == ESF_FWD;
  endsequence

  sequence s_own_out;
    cr_out_valid && cr_out_resp == CR_NONE;
  endsequence

  own_reply_a: assert property ( // RULE21
    snp_take && !sn_hit |=> s_own_out)
    else $error("untracked snoop not answered locally with empty reply");

  fwd_hit_a: assert property ( // RULE21
    snp_take && sn_hit |=> s_fwd_out ##0 snp_m_addr == $past(snp_in_addr))
    else $error("tracked snoop not forwarded with its address");

  alloc_track_a: assert property ( // RULE4
    do_alloc |=> valid_ff[$past(fr_idx)] && tag_ff[$past(fr_idx)] == $past(rd_line))
    else $error("allocating read did not create an entry");

  evict_clear_a: assert property ( // RULE6
    wr_evict && wr_hit |=> !valid_ff[$past(wr_idx)])
    else $error("evicting write left the entry valid");

  no_dup_a: assert property ( // RULE17
    rd_alloc && rd_hit && quiet |=> cnt_ff == $past(cnt_ff))
    else $error("repeat allocation changed the entry count");

  nosnoop_a: assert property ( // RULE16
    rd_obs_fire && rd_nosnp && quiet |=> valid_ff == $past(valid_ff))
    else $error("non-snooping read changed tracking");

  no_change_a: assert property ( // RULE5
    rd_obs_fire && (rd_obs_snoop == CLN_SHARED || rd_obs_snoop == RD_NOSNP_ONCE) && quiet
    |=> valid_ff == $past(valid_ff))
    else $error("non-allocating request changed tracking");

  release_a: assert property ( // RULE22
    state_ff == ESF_EVR && cr_m_fire && sn_hit && !cr_m_resp[CR_SHARED]
    |=> !valid_ff[$past(sn_idx)] ##0 state_ff == ESF_IDLE)
    else $error("reclaimed line not released after unshared reply");

  reclaim_type_a: assert property ( // RULE20
    state_ff == ESF_IDLE && ev_need && valid_ff[vict_ff]
    |=> snp_m_valid && snp_m_type == SNP_RECLAIM)
    else $error("reclaim snoop not issued with reclaim type");

  shared_keep_a: assert property ( // RULE10
    state_ff == ESF_WAIT && cr_m_fire && cr_m_resp[CR_SHARED] && sn_hit &&
    !rd_evict && !wr_evict
    |=> valid_ff[$past(sn_idx)])
    else $error("shared snoop reply dropped the line");

  rd_evict_a: assert property ( // RULE6
    rd_evict && rd_hit |=> !valid_ff[$past(rd_idx)])
    else $error("evicting read left the entry valid");

  wr_keep_a: assert property ( // RULE5
    wr_obs_fire && (wr_obs_snoop == WR_LINE_UNQ || wr_obs_snoop == WR_CLEAN) &&
    !rd_obs_fire && !cr_m_fire
    |=> valid_ff == $past(valid_ff))
    else $error("non-evicting write changed tracking");

  fwd_release_a: assert property ( // RULE10
    state_ff == ESF_WAIT && cr_m_fire && sn_hit && !cr_m_resp[CR_SHARED]
    |=> !valid_ff[$past(sn_idx)])
    else $error("unshared snoop reply kept the line");

  ovf_flag_a: assert property ( // RULE18
    rd_alloc && !rd_hit && !fr_any |=> overflow)
    else $error("dropped allocation did not raise overflow");

  reply_hold_a: assert property ( // RULE21
    cr_out_valid && !cr_out_ready |=> cr_out_valid && $stable(cr_out_resp))
    else $error("snoop reply withdrawn before it was taken");

  snoop_hold_a: assert property ( // RULE21
    snp_m_valid && !snp_m_ready
    |=> snp_m_valid && $stable(snp_m_addr) && $stable(snp_m_type))
    else $error("snoop toward master changed before it was taken");

endmodule : esf_filter

// [logic/esf_match.sv]
/*
  Fully associative line lookup: hit and index for a key, and lowest free slot.
  Assumes tags of invalid entries are don't-care.
*/
`timescale 1ns/10ps
module esf_match
  import esf_pkg::*;
#(
  parameter int DEPTH = 68,
  parameter int TW    = 26,
  parameter int IW    = 7
) (
  input  wire logic [DEPTH-1:0]         valid,
  input  wire logic [DEPTH-1:0][TW-1:0] tags,
  input  wire logic [TW-1:0]            key,
  output logic                          hit,
  output logic [IW-1:0]                 hit_idx,
  output logic                          free,
  output logic [IW-1:0]                 free_idx
);

  initial begin
    if (DEPTH < 2 || (1 << IW) < DEPTH) $error("esf_match: bad DEPTH or IW");
  end

  // scan from the top so the lowest index wins
  always_comb begin
    hit      = 1'b0;
    hit_idx  = '0;
    free     = 1'b0;
    free_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (valid[i] && tags[i] == key) begin
        hit     = 1'b1;
        hit_idx = IW'(i);
      end
      if (!valid[i]) begin
        free     = 1'b1;
        free_idx = IW'(i);
      end
    end
  end

endmodule : esf_match

// [logic/esf_pkg.sv]
/*
  Constants, encodings and state type for the external snoop filter.
  Assumes the observed request fields and snoop channels use the encodings below.
*/
// Overview of operation
// RULE1: watch every master request that could allocate a line in its cache.
// RULE2: watch evictions too: local evictions, write-backs and evicting snoops.
// RULE3: a line may be dropped once its WriteEvict has been seen.
// RULE4: allocating reads and CleanUnique or MakeUnique mark the line allocated.
// RULE5: ReadOnce, CleanShared, WriteUnique, WriteLineUnique, WriteClean change nothing.
// RULE6: CleanInvalid, MakeInvalid, WriteBack, WriteEvict and Evict mark the line evicted.
// RULE7: master issues Evict whenever its real allocation differs from the inferred one.
// RULE8: tracking updates ignore the response; errors change nothing.
// RULE9: master fixes the record itself if an error changes its allocation.
// RULE10: watch snoop channels; shared bit of the reply decides whether line stays.
// RULE11: master returns an accurate shared bit in every snoop reply.
// RULE12: master never makes the filter think a held line is gone.
// RULE13: master should not overlap allocating and evicting requests for one line.
// RULE14: on overlap the master drops the line until a clean allocation completes.
// RULE15: after overlaps finish the master settles the line with one more request.
// RULE16: non-snooping reads and writes never create entries.
// RULE17: look up before adding; never two entries for one line.
// RULE18: capacity covers every line the cache can hold.
// RULE19: extra entries cover lines in flight or in other master buffers.
// RULE20: near capacity the filter snoops lines out of the master to free entries.
// RULE21: forward snoops only for tracked lines; else answer no data, not shared.
// RULE22: release a reclaimed entry once its snoop reply shows the line gone.
package esf_pkg;

  localparam int ESF_ADDR_W     = 32;
  localparam int ESF_LINE_LOG2  = 6;
  localparam int ESF_LINES      = 64;
  localparam int ESF_EXTRA      = 4;
  localparam int ESF_SNP_W      = 4;
  localparam int ESF_CR_W       = 5;

  // read request snoop field
  localparam logic [3:0] RD_NOSNP_ONCE = 4'h0;
  localparam logic [3:0] RD_SHARED     = 4'h1;
  localparam logic [3:0] RD_CLEAN      = 4'h2;
  localparam logic [3:0] RD_NSD        = 4'h3;
  localparam logic [3:0] RD_UNIQUE     = 4'h7;
  localparam logic [3:0] CLN_SHARED    = 4'h8;
  localparam logic [3:0] CLN_INVAL     = 4'h9;
  localparam logic [3:0] CLN_UNIQUE    = 4'hB;
  localparam logic [3:0] MK_UNIQUE     = 4'hC;
  localparam logic [3:0] MK_INVAL      = 4'hD;

  // write request snoop field
  localparam logic [2:0] WR_NOSNP_UNQ  = 3'h0;
  localparam logic [2:0] WR_LINE_UNQ   = 3'h1;
  localparam logic [2:0] WR_CLEAN      = 3'h2;
  localparam logic [2:0] WR_BACK       = 3'h3;
  localparam logic [2:0] WR_DROP       = 3'h4;
  localparam logic [2:0] WR_EVICT      = 3'h5;

  localparam logic [1:0] DOM_NONSH     = 2'h0;
  localparam logic [1:0] DOM_SYSTEM    = 2'h3;

  // snoop reply bit positions
  localparam int CR_DATA   = 0;
  localparam int CR_ERR    = 1;
  localparam int CR_DIRTY  = 2;
  localparam int CR_SHARED = 3;
  localparam int CR_UNIQUE = 4;
  localparam logic [4:0] CR_NONE = 5'h00;

  localparam logic [3:0] SNP_RECLAIM = 4'h9;

  typedef enum logic [2:0] {
    ESF_IDLE = 3'h0,
    ESF_FWD  = 3'h1,
    ESF_WAIT = 3'h3,
    ESF_RET  = 3'h2,
    ESF_OWN  = 3'h6,
    ESF_EVS  = 3'h4,
    ESF_EVR  = 3'h5
  } esf_state_t;

endpackage : esf_pkg

// [test/esf_master_model.sv]
/*
  Cached master seen from its snoop channels: takes snoops, replies after a
  random delay with data and a commanded shared bit.
  Assumes one snoop outstanding at a time, all on clk_sys.
*/
`timescale 1ns/10ps
module esf_master_model
  import esf_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic                 snp_m_valid,
  output logic                      snp_m_ready,
  input  wire logic [ESF_SNP_W-1:0] snp_m_type,
  output logic                      cr_m_valid,
  input  wire logic                 cr_m_ready,
  output logic [ESF_CR_W-1:0]       cr_m_resp,
  input  wire logic                 shared_in,
  input  wire logic                 stall,
  output logic [ESF_SNP_W-1:0]      last_type
);
  int         seed = 47266;
  logic       pend;
  logic [1:0] dly;

  always @(posedge clk_sys) begin
    if (!nrst) begin
      snp_m_ready <= 1'b0;
      cr_m_valid  <= 1'b0;
      cr_m_resp   <= 5'h15;
      pend        <= 1'b0;
      last_type   <= 4'h0;
    end else begin
      if (snp_m_valid && snp_m_ready) begin
        snp_m_ready <= 1'b0;
        pend        <= 1'b1;
        last_type   <= snp_m_type;
        dly         <= 2'($random(seed));
      end else if (snp_m_valid && !stall && !pend && !cr_m_valid) begin
        snp_m_ready <= 1'b1;
      end
      if (pend) begin
        if (dly == 2'h0) begin
          cr_m_valid <= 1'b1;
          pend       <= 1'b0;
          cr_m_resp  <= {1'b0, shared_in, 3'h1};
        end else begin
          dly <= dly - 2'h1;
        end
      end
      if (cr_m_valid && cr_m_ready) begin
        cr_m_valid <= 1'b0;
        // released reply shows no stale value
        cr_m_resp  <= ~cr_m_resp;
      end
    end
  end
endmodule : esf_master_model

// [test/external_snoop_filter_bench.sv]
/*
  Self-checking bench for the snoop filter: allocation table, snoop
  filtering, reclaim and overflow. Assumes the package encodings.
*/
`timescale 1ns/10ps
module external_snoop_filter_bench;
  import esf_pkg::*;
  localparam int DEPTH = ESF_LINES + ESF_EXTRA;
  logic clk_sys = 0, nrst = 0;
  logic rd_obs_fire = 0, rd_obs_bar = 0, wr_obs_fire = 0, wr_obs_bar = 0;
  logic [31:0] rd_obs_addr = 0, wr_obs_addr = 0, snp_in_addr = 0, snp_m_addr;
  logic [3:0] rd_obs_snoop = 0, snp_in_type = 0, snp_m_type, last_type;
  logic [2:0] wr_obs_snoop = 0;
  logic [1:0] rd_obs_domain = 0, wr_obs_domain = 0;
  logic snp_in_valid = 0, snp_in_ready, cr_out_valid, cr_out_ready = 1;
  logic snp_m_valid, snp_m_ready, cr_m_valid, cr_m_ready, overflow;
  logic shared_in = 1, stall = 0;
  logic [4:0] cr_out_resp, cr_m_resp;
  logic [6:0] tracked_count;
  logic [4:0] expq[$];
  int seed = 47266, miscompares = 0, n_checks = 0, cyc = 0, i;

  esf_filter u_esf_filter (.clk_sys(clk_sys), .nrst(nrst), .rd_obs_fire(rd_obs_fire),
    .rd_obs_addr(rd_obs_addr), .rd_obs_snoop(rd_obs_snoop), .rd_obs_domain(rd_obs_domain),
    .rd_obs_bar(rd_obs_bar), .wr_obs_fire(wr_obs_fire), .wr_obs_addr(wr_obs_addr),
    .wr_obs_snoop(wr_obs_snoop), .wr_obs_domain(wr_obs_domain), .wr_obs_bar(wr_obs_bar),
    .snp_in_valid(snp_in_valid), .snp_in_ready(snp_in_ready), .snp_in_addr(snp_in_addr),
    .snp_in_type(snp_in_type), .cr_out_valid(cr_out_valid), .cr_out_ready(cr_out_ready),
    .cr_out_resp(cr_out_resp), .snp_m_valid(snp_m_valid), .snp_m_ready(snp_m_ready),
    .snp_m_addr(snp_m_addr), .snp_m_type(snp_m_type), .cr_m_valid(cr_m_valid),
    .cr_m_ready(cr_m_ready), .cr_m_resp(cr_m_resp), .tracked_count(tracked_count),
    .overflow(overflow));
  esf_master_model u_esf_master_model (.clk_sys(clk_sys), .nrst(nrst),
    .snp_m_valid(snp_m_valid), .snp_m_ready(snp_m_ready), .snp_m_type(snp_m_type),
    .cr_m_valid(cr_m_valid), .cr_m_ready(cr_m_ready), .cr_m_resp(cr_m_resp),
    .shared_in(shared_in), .stall(stall), .last_type(last_type));

  always #25 clk_sys = ~clk_sys;

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // hang guard: whole run is about a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test;
    end
  end

  // oldest noted reply is compared when the filter answers
  always @(posedge clk_sys) begin
    if (cr_out_valid && cr_out_ready) begin
      if (expq.size() == 0) chk(8'h1, 8'h0);
      else chk({3'h0, cr_out_resp}, {3'h0, expq.pop_front()});
    end
  end

  // back-pressure makes the reply stand for a while
  always @(posedge clk_sys) cr_out_ready <= ($random(seed) & 3) != 0;

  // toward the master: the snoop's own address, or a whole line when reclaiming
  always @(posedge clk_sys) begin
    if (snp_m_valid && snp_m_ready && snp_m_type != SNP_RECLAIM)
      chk({7'h0, snp_m_addr != snp_in_addr}, 8'h0);
    else if (snp_m_valid && snp_m_ready)
      chk({2'h0, snp_m_addr[5:0]}, 8'h0);
  end

  function automatic logic [31:0] adr(input int line);
    adr = (line << 6) | ($random(seed) & 63);
  endfunction : adr

  function automatic logic [1:0] sdom();
    sdom = 2'(1 + ($random(seed) & 1));
  endfunction : sdom

  task obs(input logic rd, input int line, input logic [3:0] code, input logic [1:0] dom,
           input logic bar);
    @(posedge clk_sys);
    if (rd) begin
      rd_obs_fire <= 1; rd_obs_addr <= adr(line); rd_obs_snoop <= code;
      rd_obs_domain <= dom; rd_obs_bar <= bar;
    end else begin
      wr_obs_fire <= 1; wr_obs_addr <= adr(line); wr_obs_snoop <= code[2:0];
      wr_obs_domain <= dom; wr_obs_bar <= bar;
    end
    @(posedge clk_sys);
    rd_obs_fire <= 0;
    wr_obs_fire <= 0;
  endtask : obs

  task snoop(input int line, input logic [4:0] exp);
    int n;
    n = 0;
    expq.push_back(exp);
    @(posedge clk_sys);
    snp_in_valid <= 1; snp_in_addr <= adr(line); snp_in_type <= 4'h1;
    do @(negedge clk_sys); while (snp_in_ready !== 1'b1 && ++n < 100);
    @(posedge clk_sys);
    snp_in_valid <= 0;
    while (expq.size() != 0 && ++n < 200) @(posedge clk_sys);
  endtask : snoop

  task cnt(input int e);
    repeat (3) @(posedge clk_sys);
    chk({1'b0, tracked_count}, e[7:0]);
  endtask : cnt

  logic [3:0] alloc_codes[6] = '{RD_SHARED, RD_CLEAN, RD_NSD, RD_UNIQUE, CLN_UNIQUE, MK_UNIQUE};

  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1;
    cnt(0);
    for (i = 0; i < 12; i++) obs(1, 1 + i % 6, alloc_codes[i % 6], sdom(), 0);
    cnt(6);
    $display("allocation test done");
    obs(1, 20, RD_NOSNP_ONCE, DOM_NONSH, 0); obs(1, 21, RD_NOSNP_ONCE, DOM_SYSTEM, 0);
    obs(0, 22, WR_NOSNP_UNQ, DOM_NONSH, 0); obs(0, 23, WR_NOSNP_UNQ, DOM_SYSTEM, 0);
    obs(1, 24, RD_NOSNP_ONCE, sdom(), 0); obs(1, 25, CLN_SHARED, sdom(), 0);
    obs(0, 26, WR_NOSNP_UNQ, sdom(), 0); obs(0, 27, WR_LINE_UNQ, sdom(), 0);
    obs(0, 28, WR_CLEAN, sdom(), 0); obs(1, 29, RD_SHARED, sdom(), 1);
    cnt(6);
    $display("no-allocation test done");
    snoop(1, 5'h09);
    snoop(40, CR_NONE);
    cnt(6);
    shared_in <= 0;
    snoop(2, 5'h01);
    cnt(5);
    snoop(2, CR_NONE);
    $display("snoop test done");
    // evicts only lines the model no longer holds
    obs(1, 1, CLN_INVAL, sdom(), 0); obs(1, 3, MK_INVAL, sdom(), 0);
    obs(0, 4, WR_BACK, sdom(), 0); obs(0, 5, WR_EVICT, sdom(), 0);
    obs(0, 6, WR_DROP, sdom(), 0); obs(1, 2, CLN_INVAL, sdom(), 0);
    cnt(0);
    $display("eviction test done");
    for (i = 0; i < 70; i++) begin
      obs(1, 100 + i, RD_UNIQUE, sdom(), 0);
      repeat (8) @(posedge clk_sys);
    end
    cnt(DEPTH - 2);
    chk({4'h0, last_type}, {4'h0, SNP_RECLAIM});
    chk({7'h0, overflow}, 8'h0);
    $display("reclaim test done");
    stall <= 1;
    for (i = 0; i < 4; i++) obs(1, 300 + i, RD_CLEAN, sdom(), 0);
    cnt(DEPTH);
    chk({7'h0, overflow}, 8'h1);
    chk({7'h0, snp_in_ready}, 8'h0);
    stall <= 0;
    repeat (60) @(posedge clk_sys);
    cnt(DEPTH - 2);
    chk({7'h0, overflow}, 8'h1);
    $display("overflow test done");
    end_of_test;
  end
endmodule : external_snoop_filter_bench
